// File: verification/urf_rx_flags_test.sv
// Self-checking bench for the receive flag block, driven over APB.
// Assumes the serial source model on rx_line and BAUD at 0 during frames.
`timescale 1ns/1ps
`include "urf_map.svh"
module urf_rx_flags_test
  import urf_pkg::*;
;
  localparam logic [31:0] M_FULL = 32'h1 << `URF_STAT_FULL;
  localparam logic [31:0] M_IDLE = 32'h1 << `URF_STAT_IDLE;
  localparam logic [31:0] M_OVR  = 32'h1 << `URF_STAT_OVR;
  localparam logic [31:0] M_NF   = 32'h1 << `URF_STAT_NF;
  localparam logic [31:0] C_ILT  = 32'h1 << `URF_CTRL_ILT;
  localparam logic [31:0] C_NINE = 32'h1 << `URF_CTRL_NINE;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rx_line;
  logic [7:0]  paddr, tx_gat;
  logic [31:0] pwdata, prdata, rd;
  logic        err, tx_send, tx_nine, tx_gen, tx_busy;
  logic [8:0]  tx_char;
  logic [7:0]  noise_at [3] = '{8'h05, 8'h48, 8'h98};
  int          fail_count = 0;
  int          tests_run = 0;

  urf_rx_flags #(.AW(8)) dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_line(rx_line));
  urf_serial_src src (.clk(clk), .rst(rst), .send(tx_send),
    .char_in(tx_char), .nine(tx_nine), .glitch_en(tx_gen),
    .glitch_at(tx_gat), .busy(tx_busy), .rx_line(rx_line));

  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; a trailing idle cycle keeps psel from being
  // assigned twice in one time step when calls follow each other
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    check({31'h0, n < 50}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic st_chk(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, `URF_ADDR_STAT, 32'h0);
    check(rd & mask, exp);
  endtask

  task automatic clr();
    apb(1'b0, `URF_ADDR_STAT, 32'h0);
    apb(1'b0, `URF_ADDR_DATA, 32'h0);
  endtask

  task automatic send(input logic [8:0] c, input logic g,
                      input logic [7:0] at);
    int n;
    tx_char <= c;
    tx_gen  <= g;
    tx_gat  <= at;
    tx_send <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_busy !== 1'b1 && n < 10);
    tx_send <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_busy !== 1'b0 && n < 300);
    check({31'h0, n < 300}, 32'h1);
  endtask

  initial begin
    clk     = 1'b0;
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    tx_send = 1'b0;
    tx_nine = 1'b0;
    tx_gen  = 1'b0;
    tx_gat  = 8'h00;
    tx_char = 9'h000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (200) @(posedge clk);
    st_chk(32'hffffffff, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `URF_ADDR_STAT, 32'hff);
    check({31'h0, err}, 32'h0);
    apb(1'b1, `URF_ADDR_CTRL, C_ILT);
    apb(1'b0, `URF_ADDR_CTRL, 32'h0);
    check(rd, C_ILT);
    // Short divider only while the line is quiet; restored before frames
    apb(1'b1, `URF_ADDR_BAUD, 32'h3);
    apb(1'b0, `URF_ADDR_BAUD, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, `URF_ADDR_BAUD, 32'h0);
    apb(1'b1, `URF_ADDR_CTRL, 32'h0);
    // A data read with no status read before it must not clear
    send(9'h05a, 1'b0, 8'h00);
    apb(1'b0, `URF_ADDR_DATA, 32'h0);
    check(rd, 32'h5a);
    st_chk(M_FULL | M_NF | M_OVR, M_FULL);
    clr();
    // Quiet counting from the start bit: all-ones char counts early
    send(9'h0ff, 1'b0, 8'h00);
    repeat (40) @(posedge clk);
    st_chk(M_IDLE, M_IDLE);
    clr();
    st_chk(M_IDLE, 32'h0);
    repeat (200) @(posedge clk);
    st_chk(M_IDLE, 32'h0);
    apb(1'b1, `URF_ADDR_CTRL, C_ILT);
    send(9'h0ff, 1'b0, 8'h00);
    repeat (48) @(posedge clk);
    st_chk(M_IDLE, 32'h0);
    repeat (150) @(posedge clk);
    st_chk(M_IDLE, M_IDLE);
    clr();
    apb(1'b1, `URF_ADDR_CTRL, C_ILT | C_NINE);
    apb(1'b0, `URF_ADDR_CTRL, 32'h0);
    check(rd, C_ILT | C_NINE);
    tx_nine <= 1'b1;
    send(9'h1ff, 1'b0, 8'h00);
    repeat (164) @(posedge clk);
    st_chk(M_IDLE, 32'h0);
    repeat (24) @(posedge clk);
    st_chk(M_IDLE, M_IDLE);
    apb(1'b0, `URF_ADDR_DATA, 32'h0);
    check(rd, 32'h1ff);
    apb(1'b1, `URF_ADDR_CTRL, 32'h0);
    tx_nine <= 1'b0;
    // Noisy second char is dropped with its noise mark
    send(9'h011, 1'b0, 8'h00);
    send(9'h022, 1'b1, 8'h48);
    st_chk(M_FULL | M_OVR | M_NF, M_FULL | M_OVR);
    apb(1'b0, `URF_ADDR_DATA, 32'h0);
    check(rd, 32'h11);
    st_chk(M_FULL | M_OVR, 32'h0);
    // Glitch in the start bit, a data bit and the stop bit in turn
    for (int i = 0; i < 3; i++) begin
      send(9'h03c, 1'b1, noise_at[i]);
      st_chk(M_FULL | M_NF | M_OVR, M_FULL | M_NF);
      apb(1'b0, `URF_ADDR_DATA, 32'h0);
      check(rd, 32'h3c);
      st_chk(M_NF, 32'h0);
    end
    test_done();
  end

  // Whole run is some 2500 clocks; this leaves wide margin for a hang
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
endmodule

// File: verification/urf_serial_src.sv
// Serial source model: one framed character per request, 16 clocks a bit,
// start bit low, data LSB first, one stop bit; may flip one clock of it.
// Assumes the receiver runs with its baud divider at reset (tick each clk).
`timescale 1ns/1ps
module urf_serial_src
  import urf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       send,
  input  wire logic [8:0] char_in,
  input  wire logic       nine,
  input  wire logic       glitch_en,
  input  wire logic [7:0] glitch_at,
  output logic            busy,
  output logic            rx_line
);
  logic [10:0] frame_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  len_reg;
  logic        gen_reg;
  logic [7:0]  gat_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      rx_line   <= 1'b1;
      frame_reg <= '1;
      cnt_reg   <= 8'h00;
      len_reg   <= 8'ha0;
      gen_reg   <= 1'b0;
      gat_reg   <= 8'h00;
    end else if (!busy) begin
      // Line rests high between frames
      rx_line <= 1'b1;
      if (send) begin
        busy      <= 1'b1;
        cnt_reg   <= 8'h00;
        frame_reg <= nine ? {1'b1, char_in, 1'b0}
                          : {2'b11, char_in[7:0], 1'b0};
        len_reg   <= nine ? 8'hb0 : 8'ha0;
        gen_reg   <= glitch_en;
        gat_reg   <= glitch_at;
      end
    end else if (cnt_reg == len_reg) begin
      busy    <= 1'b0;
      rx_line <= 1'b1;
    end else begin
      // One flipped clock hits a single sample, so the vote still holds
      rx_line <= frame_reg[cnt_reg[7:4]] ^ (gen_reg && cnt_reg == gat_reg);
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// File: verilog/urf_map.svh
// Addresses, field positions, reset values and timing counts of the
// receive status flag block. Included by both design modules.
`ifndef URF_MAP_SVH
`define URF_MAP_SVH

`define URF_ADDR_STAT    8'h00
`define URF_ADDR_DATA    8'h04
`define URF_ADDR_CTRL    8'h08
`define URF_ADDR_BAUD    8'h0c

`define URF_STAT_FULL    5
`define URF_STAT_IDLE    4
`define URF_STAT_OVR     3
`define URF_STAT_NF      2
`define URF_CTRL_NINE    4
`define URF_CTRL_ILT     2

`define URF_PEND_FULL    3
`define URF_PEND_IDLE    2
`define URF_PEND_OVR     1
`define URF_PEND_NF      0

`define URF_BAUD_RST     16'h0000
`define URF_OS_TICKS     8'h10
`define URF_START_LO     4'h2
`define URF_START_HI     4'h8
`define URF_BIT_LO       4'h7
`define URF_BIT_HI       4'h9
`define URF_STOP_DONE    4'ha
`define URF_BIT_END      4'hf
`define URF_START_SMPS   3'h7
`define URF_BIT_SMPS     3'h3
`define URF_IDLE_BITS_8  8'h0a
`define URF_IDLE_BITS_9  8'h0b

`endif

// File: verilog/urf_pkg.sv
// Types shared by the receive flag block and its frame shifter.
// Assumes urf_map.svh supplies the addresses, field positions and timing counts.
package urf_pkg;
  typedef enum logic [3:0] {
    URF_WAIT  = 4'h1,
    URF_START = 4'h2,
    URF_DATA  = 4'h4,
    URF_STOP  = 4'h8
  } urf_rx_state_type;

  typedef struct packed {
    urf_rx_state_type st;
    logic [3:0]       os;
    logic [3:0]       bidx;
    logic [2:0]       ones;
    logic [2:0]       nsmp;
    logic             noise;
    logic [8:0]       data;
    logic             done;
  } urf_rx_type;

  typedef struct packed {
    logic [15:0] div_cnt;
    logic        tick;
    logic [15:0] baud;
    logic        nine;
    logic        quiet_count_start_select;
    logic [8:0]  data;
    logic        full;
    logic        ovr;
    logic        nf;
    logic        idle;
    logic        armed;
    logic [7:0]  idle_cnt;
    logic [3:0]  pend;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } urf_top_type;
endpackage

// File: verilog/urf_rx_flags.sv
// Receive status flags behind an APB slave: quiet line, overrun, noise.
// Assumes an APB master on clk and a receive line synchronous to clk.
`timescale 1ns/1ps
`include "urf_map.svh"
module urf_rx_flags
  import urf_pkg::*;
#(
  parameter int AW = 8
)(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          rx_line
);
  generate
    if (AW < 4 || AW > 32) begin : g_bad_aw
      $error("AW must lie between 4 and 32");
    end
  endgenerate

  urf_top_type r_reg;
  urf_top_type r_next;

  logic       ch_done;
  logic [8:0] ch_data;
  logic       ch_noise;
  logic       ch_busy;
  logic       acc;
  logic       srd;
  logic       drd;
  logic [3:0] clr;
  logic       full_eff;
  logic [7:0] thr;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    off);
    return a == AW'(off);
  endfunction

  urf_rx_shifter u_shift (
    .clk     (clk),
    .rst     (rst),
    .rx      (rx_line),
    .os_tick (r_reg.tick),
    .nine    (r_reg.nine),
    .done    (ch_done),
    .data    (ch_data),
    .noise   (ch_noise),
    .busy    (ch_busy)
  );

  // Completion edge of an APB transfer; one wait state is always added
  assign acc = psel && penable && r_reg.pready;
  assign srd = acc && !pwrite && hit(paddr, `URF_ADDR_STAT);
  assign drd = acc && !pwrite && hit(paddr, `URF_ADDR_DATA);
  assign clr = drd ? r_reg.pend : 4'h0;
  assign full_eff = r_reg.full && !clr[`URF_PEND_FULL];
  assign thr = (r_reg.nine ? `URF_IDLE_BITS_9 : `URF_IDLE_BITS_8) *
               `URF_OS_TICKS;

  always_comb begin
    r_next = r_reg;

    // Oversample tick: baud + 1 clocks per tick, sixteen ticks per bit
    r_next.tick = (r_reg.div_cnt == 16'h0000);
    r_next.div_cnt = r_next.tick ? r_reg.baud
                                 : 16'(r_reg.div_cnt - 16'h0001);

    // APB answer, registered so the outputs come from flops
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h0000_0000;
      if (hit(paddr, `URF_ADDR_STAT)) begin
        r_next.prdata[`URF_STAT_FULL] = r_reg.full;
        r_next.prdata[`URF_STAT_IDLE] = r_reg.idle;
        r_next.prdata[`URF_STAT_OVR] = r_reg.ovr;
        r_next.prdata[`URF_STAT_NF] = r_reg.nf;
      end else if (hit(paddr, `URF_ADDR_DATA)) begin
        r_next.prdata[8:0] = r_reg.data;
      end else if (hit(paddr, `URF_ADDR_CTRL)) begin
        r_next.prdata[`URF_CTRL_NINE] = r_reg.nine;
        r_next.prdata[`URF_CTRL_ILT] = r_reg.quiet_count_start_select;
      end else if (hit(paddr, `URF_ADDR_BAUD)) begin
        r_next.prdata[15:0] = r_reg.baud;
      end else begin
        r_next.pslverr = 1'b1;
      end
    end

    if (acc && pwrite) begin
      if (hit(paddr, `URF_ADDR_CTRL)) begin
        r_next.nine = pwdata[`URF_CTRL_NINE];
        r_next.quiet_count_start_select = pwdata[`URF_CTRL_ILT];
      end else if (hit(paddr, `URF_ADDR_BAUD)) begin
        r_next.baud = pwdata[15:0];
      end
    end

    // First step of the clear: remember the flags software actually saw
    if (srd) begin
      r_next.pend[`URF_PEND_FULL] = r_reg.prdata[`URF_STAT_FULL];
      r_next.pend[`URF_PEND_IDLE] = r_reg.prdata[`URF_STAT_IDLE];
      r_next.pend[`URF_PEND_OVR] = r_reg.prdata[`URF_STAT_OVR];
      r_next.pend[`URF_PEND_NF] = r_reg.prdata[`URF_STAT_NF];
    end else if (drd) begin
      r_next.pend = 4'h0;
    end

    // Second step: a data read clears what was seen; sets below win
    r_next.full = full_eff;
    r_next.idle = r_reg.idle && !clr[`URF_PEND_IDLE];
    r_next.ovr = r_reg.ovr && !clr[`URF_PEND_OVR];
    r_next.nf = r_reg.nf && !clr[`URF_PEND_NF];

    // Quiet-line timer in oversample ticks, saturating at the threshold;
    // a shorter quiet time chosen mid-count pulls it down at once
    if (r_reg.tick && (!rx_line || (r_reg.quiet_count_start_select && ch_busy))) begin
      r_next.idle_cnt = 8'h00;
    end else if (r_reg.idle_cnt > thr) begin
      r_next.idle_cnt = thr;
    end else if (r_reg.tick && r_reg.idle_cnt < thr) begin
      r_next.idle_cnt = 8'(r_reg.idle_cnt + 8'h01);
    end

    // Only one report per quiet period; rearmed by the next loaded character, not one lost to overrun
    if (r_reg.armed && r_reg.idle_cnt >= thr) begin
      r_next.idle = 1'b1;
      r_next.armed = 1'b0;
    end

    if (ch_done) begin
      if (full_eff) begin
        r_next.ovr = 1'b1;
      end else begin
        r_next.data = ch_data;
        r_next.full = 1'b1;
        r_next.nf = ch_noise;
        r_next.armed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{baud: `URF_BAUD_RST, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign pready  = r_reg.pready;
  assign prdata  = r_reg.prdata;
  assign pslverr = r_reg.pslverr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_load;
    ch_done && !full_eff;
  endsequence

  sequence s_lost;
    ch_done && full_eff;
  endsequence

  sequence s_stat_saw_idle;
    srd && r_reg.prdata[`URF_STAT_IDLE];
  endsequence

  property p_idle_cause;
    !r_reg.idle ##1 r_reg.idle |-> $past(r_reg.armed) &&
                                   $past(r_reg.idle_cnt) >= $past(thr);
  endproperty
  a_idle_cause: assert property (p_idle_cause)
    else $error("quiet flag rose without armed full character time");

  property p_idle_thr;
    $stable(r_reg.nine)
      |-> r_reg.idle_cnt <= (r_reg.nine ? 8'hb0 : 8'ha0);
  endproperty
  a_idle_thr: assert property (p_idle_thr)
    else $error("quiet timer passed the character time");

  property p_ilt0_count;
    r_reg.tick && !r_reg.quiet_count_start_select && rx_line && r_reg.idle_cnt < thr
      |=> r_reg.idle_cnt == 8'($past(r_reg.idle_cnt) + 8'h01);
  endproperty
  a_ilt0_count: assert property (p_ilt0_count)
    else $error("quiet timer stalled on a high tick");

  property p_ilt1_hold;
    r_reg.tick && r_reg.quiet_count_start_select && ch_busy |=> r_reg.idle_cnt == 8'h00;
  endproperty
  a_ilt1_hold: assert property (p_ilt1_hold)
    else $error("quiet timer ran inside a frame");

  sequence s_data_saw_idle;
    drd && r_reg.pend[`URF_PEND_IDLE];
  endsequence

  property p_idle_seen;
    s_stat_saw_idle |=> r_reg.pend[`URF_PEND_IDLE];
  endproperty
  a_idle_seen: assert property (p_idle_seen)
    else $error("status read did not record the quiet flag");

  property p_idle_clear;
    s_data_saw_idle ##0 !(r_reg.armed && r_reg.idle_cnt >= thr)
      |=> !r_reg.idle;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("quiet flag survived status then data read");

  property p_idle_hold;
    r_reg.idle && !clr[`URF_PEND_IDLE] |=> r_reg.idle;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("quiet flag dropped without the clear sequence");

  property p_idle_once;
    !r_reg.idle && !r_reg.armed |=> !r_reg.idle;
  endproperty
  a_idle_once: assert property (p_idle_once)
    else $error("quiet flag rearmed without a new character");

  property p_armed_load;
    s_load |=> r_reg.armed;
  endproperty
  a_armed_load: assert property (p_armed_load)
    else $error("new character did not rearm the quiet flag");

  property p_ovr_set;
    s_lost |=> r_reg.ovr;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not flagged");

  property p_ovr_keep;
    s_lost |=> r_reg.data == $past(r_reg.data) &&
               r_reg.nf == $past(r_reg.nf);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("held character changed on overrun");

  property p_full_keep;
    s_lost |=> r_reg.full;
  endproperty
  a_full_keep: assert property (p_full_keep)
    else $error("receive full dropped on overrun");

  property p_data_hold;
    !ch_done |=> r_reg.data == $past(r_reg.data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("held character changed without a new one");

  property p_ovr_clear;
    drd && r_reg.pend[`URF_PEND_OVR] && !ch_done |=> !r_reg.ovr;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun survived status then data read");

  property p_ovr_hold;
    r_reg.ovr && !clr[`URF_PEND_OVR] |=> r_reg.ovr;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("overrun dropped without the clear sequence");

  property p_nf_with_full;
    s_load |=> r_reg.full && r_reg.nf == $past(ch_noise);
  endproperty
  a_nf_with_full: assert property (p_nf_with_full)
    else $error("noise flag not loaded with the character");

  property p_nf_clear;
    drd && r_reg.pend[`URF_PEND_NF] && !ch_done |=> !r_reg.nf;
  endproperty
  a_nf_clear: assert property (p_nf_clear)
    else $error("noise flag survived status then data read");

  property p_nf_hold;
    r_reg.nf && !clr[`URF_PEND_NF] |=> r_reg.nf;
  endproperty
  a_nf_hold: assert property (p_nf_hold)
    else $error("noise flag dropped without the clear sequence");

  property p_full_load;
    s_load |=> r_reg.full && r_reg.data == $past(ch_data);
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("character not moved into data register");
endmodule

// File: verilog/urf_rx_shifter.sv
// Oversampled frame receiver: start detect, voted bits, noise marking.
// Assumes os_tick pulses sixteen times per bit and rx is synchronous.
`timescale 1ns/1ps
`include "urf_map.svh"
module urf_rx_shifter
  import urf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rx,
  input  wire logic       os_tick,
  input  wire logic       nine,
  output logic            done,
  output logic [8:0]      data,
  output logic            noise,
  output logic            busy
);
  urf_rx_type r_reg;
  urf_rx_type r_next;

  function automatic logic mixed(input logic [2:0] ones,
                                 input logic [2:0] n);
    return (ones != 3'h0) && (ones != n);
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (os_tick) begin
      r_next.os = 4'(r_reg.os + 4'h1);
      case (r_reg.st)
        URF_WAIT: begin
          if (!rx) begin
            r_next.st = URF_START;
            r_next.os = 4'h1;
            r_next.ones = 3'h0;
            r_next.nsmp = 3'h0;
            r_next.noise = 1'b0;
            r_next.data = 9'h000;
          end
        end
        URF_START: begin
          if (r_reg.os >= `URF_START_LO && r_reg.os <= `URF_START_HI) begin
            r_next.ones = 3'(r_reg.ones + {2'h0, rx});
            r_next.nsmp = 3'(r_reg.nsmp + 3'h1);
          end
          if (r_reg.os == `URF_BIT_END) begin
            // Mostly high samples mean a glitch, not a start bit
            if (r_reg.ones > 3'h3) begin
              r_next.st = URF_WAIT;
            end else begin
              r_next.st = URF_DATA;
              r_next.noise = mixed(r_reg.ones, `URF_START_SMPS);
              r_next.bidx = 4'h0;
              r_next.ones = 3'h0;
              r_next.nsmp = 3'h0;
            end
          end
        end
        default: begin
          if (r_reg.os >= `URF_BIT_LO && r_reg.os <= `URF_BIT_HI) begin
            r_next.ones = 3'(r_reg.ones + {2'h0, rx});
            r_next.nsmp = 3'(r_reg.nsmp + 3'h1);
          end
          if (r_reg.st == URF_DATA && r_reg.os == `URF_BIT_END) begin
            r_next.data[r_reg.bidx] = (r_reg.ones >= 3'h2);
            r_next.noise = r_reg.noise |
                           mixed(r_reg.ones, `URF_BIT_SMPS);
            r_next.ones = 3'h0;
            r_next.nsmp = 3'h0;
            r_next.bidx = 4'(r_reg.bidx + 4'h1);
            if (r_reg.bidx == (nine ? 4'h8 : 4'h7)) begin
              r_next.st = URF_STOP;
            end
          end
          // Hand over at mid stop so a late stop edge cannot hide the data
          if (r_reg.st == URF_STOP && r_reg.os == `URF_STOP_DONE) begin
            r_next.done = 1'b1;
            r_next.noise = r_reg.noise | mixed(r_reg.ones, `URF_BIT_SMPS);
          end
          if (r_reg.st == URF_STOP && r_reg.os == `URF_BIT_END) begin
            r_next.st = URF_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{st: URF_WAIT, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign done  = r_reg.done;
  assign data  = r_reg.data;
  assign noise = r_reg.noise;
  assign busy  = (r_reg.st != URF_WAIT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_start_smp;
    os_tick && r_reg.st == URF_START && r_reg.os == `URF_BIT_END
      |-> r_reg.nsmp == `URF_START_SMPS;
  endproperty
  a_start_smp: assert property (p_start_smp)
    else $error("start bit not sampled seven times");

  property p_bit_smp;
    os_tick && r_reg.st == URF_DATA && r_reg.os == `URF_BIT_END
      |-> r_reg.nsmp == `URF_BIT_SMPS;
  endproperty
  a_bit_smp: assert property (p_bit_smp)
    else $error("data bit not sampled three times");
endmodule
